// *** ddrbm_params.svh ***
// timing counts, command codes and mode field positions of the ddr burst link
`ifndef DDRBM_PARAMS_SVH
`define DDRBM_PARAMS_SVH
// =====================================
// clock rates
`define DDRBM_CORE_PERIOD_NS 8
`define DDRBM_LINK_PERIOD_NS 64
// core cycles per half period of the link clocks
`define DDRBM_LINK_HALF (`DDRBM_LINK_PERIOD_NS / (2 * `DDRBM_CORE_PERIOD_NS))
// write data clock lags the command clock by a quarter period
`define DDRBM_DK_OFS (`DDRBM_LINK_HALF / 2)
// latencies in whole command clock periods
`define DDRBM_WL 1
`define DDRBM_RL 1
// =====================================
// command codes as {we_n, ref_n} with cs_n low
`define DDRBM_CMD_MRS 2'b00
`define DDRBM_CMD_WRITE 2'b01
`define DDRBM_CMD_REF 2'b10
`define DDRBM_CMD_READ 2'b11
// =====================================
// mode setting fields on the address lines
`define DDRBM_MR_BL_LSB 0
`define DDRBM_MR_DLL_BIT 2
`define DDRBM_BL2 2'b00
`define DDRBM_BL4 2'b01
`define DDRBM_BL8 2'b10
`define DDRBM_BL_BAD 2'b11
`endif

// *** ddrbm_pkg.sv ***
// types and shared helpers of the ddr burst memory link
`include "ddrbm_params.svh"
package ddrbm_pkg;
  // =====================================
  // request kinds on the controller user side
  typedef enum logic [1:0] {DDRBM_OP_READ, DDRBM_OP_WRITE, DDRBM_OP_REF, DDRBM_OP_MODE} ddrbm_op_t;
  // device sequencer states
  typedef enum logic [1:0] {D_IDLE, D_WR, D_RD} ddrbm_dst_t;
  // controller sequencer states
  typedef enum logic [1:0] {H_INIT, H_IDLE, H_CMD, H_BUSY} ddrbm_hst_t;

  // words in a burst for a length code
  function automatic logic [3:0] ddrbm_bl_words(input logic [1:0] code);
    case (code)
      `DDRBM_BL2: return 4'h2;
      `DDRBM_BL4: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction : ddrbm_bl_words

  // level filter: a bit moves only once stages two and three agree
  function automatic logic [3:0] ddrbm_lvl_filt(input logic [3:0] s2, input logic [3:0] s3,
                                                input logic [3:0] lvl);
    return ((s2 ~^ s3) & s3) | ((s2 ^ s3) & lvl);
  endfunction : ddrbm_lvl_filt
endpackage : ddrbm_pkg

// *** ddrbm_if.sv ***
// link wires between the memory device and its controller
`timescale 1ns/1ps
interface ddrbm_if #(
  parameter int DQ_W = 36
) ();
  // command side, launched by the controller
  logic command_clock;
  logic cs_n;
  logic we_n;
  logic ref_n;
  logic [19:0] addr;
  logic [3:0] bank;
  logic spare_chip_select;
  logic mirror_select;
  // write side
  logic write_data_clock;
  logic [1:0] write_byte_mask;
  // common data lines, one driver per end plus its enable
  logic [DQ_W-1:0] ctl_dq;
  logic ctl_dq_oe;
  logic [DQ_W-1:0] dev_dq;
  logic dev_dq_oe;
  logic [DQ_W-1:0] dq;
  // read side, launched by the device
  logic [3:0] read_data_clock;
  logic read_valid_flag;

  // resolved line level; an undriven bus reads as zero
  assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);

  modport dev (
    input command_clock, cs_n, we_n, ref_n, addr, bank, spare_chip_select, mirror_select,
    input write_data_clock, write_byte_mask, dq,
    output dev_dq, dev_dq_oe, read_data_clock, read_valid_flag
  );
  modport ctl (
    output command_clock, cs_n, we_n, ref_n, addr, bank, spare_chip_select, mirror_select,
    output write_data_clock, write_byte_mask, ctl_dq, ctl_dq_oe,
    input dq, read_data_clock, read_valid_flag
  );
endinterface : ddrbm_if

// *** ddrbm_device.sv ***
// memory device end of the ddr burst link: sampling, burst sequencer, array
//
// Behaviour
// - two data beats per clock period
// - commands sampled on command clock rise only
// - write beats captured on both data clock edges
// - read beats launched with own read clocks
// - bursts of two, four or eight words
// - per bank refresh, row counted inside
// - one read clock per nine lines
// - two-clock controller uses pairs zero, one
// - mirror select: spare select replaces address five
// - reads and writes only with loop enabled
// - chip select high ignores new commands
`timescale 1ns/1ps
`include "ddrbm_params.svh"
module ddrbm_device #(
  parameter int DQ_W = 36,
  parameter int COL_W = 6,
  parameter int ROW_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // link to the controller
  ddrbm_if.dev link,
  // status toward local logic
  output logic dll_on,
  output logic [3:0] burst_words,
  output logic refresh_pulse,
  output logic [3:0] refresh_bank,
  output logic [ROW_W-1:0] refresh_row,
  output logic ignored_pulse
);
  // =====================================
  // sizes and positions in the sampled pin vector
  localparam int NQK = DQ_W / 9; // read clocks, one per nine lines
  localparam int LANE = DQ_W / 2; // lines covered by one mask bit
  localparam int IDX_W = 4 + COL_W; // bank and column
  localparam int DEPTH = 1 << IDX_W;
  localparam int P_CK = 0;
  localparam int P_DK = 1;
  localparam int P_CS = 2;
  localparam int P_WE = 3;
  localparam int P_REF = 4;
  localparam int P_A = 5;
  localparam int P_BA = 25;
  localparam int P_SPARE = 29;
  localparam int P_MIR = 30;
  localparam int P_DM = 31;
  localparam int P_DQ = 33;
  localparam int IN_W = P_DQ + DQ_W;

  // whole control state of the device
  typedef struct packed {
    logic [IN_W-1:0] s1; // first sync stage, read only by s2
    logic [IN_W-1:0] s2;
    logic [IN_W-1:0] s3;
    logic ck_lvl; // filtered command clock
    logic dk_lvl; // filtered write data clock
    logic dll; // delay loop enabled
    logic [1:0] bl; // burst length code
    ddrbm_pkg::ddrbm_dst_t st;
    logic [3:0] bank; // burst bank
    logic [COL_W-1:0] col; // burst start column
    logic [2:0] skip; // latency edges still to pass
    logic [3:0] beat; // beats done
    logic [3:0] qk; // read clock outputs
    logic [DQ_W-1:0] dq; // read beat output
    logic oe;
    logic vld;
    logic [16*ROW_W-1:0] rows; // next row to refresh, per bank
    logic rf;
    logic [3:0] rf_bank;
    logic [ROW_W-1:0] rf_row;
    logic ign;
  } ddrbm_dev_st_t;

  ddrbm_dev_st_t r; // registered state
  ddrbm_dev_st_t n; // next state
  logic [DQ_W-1:0] mem [DEPTH]; // storage array
  logic mem_we; // write strobe for one beat
  logic [IDX_W-1:0] mem_idx; // word addressed by the current beat
  logic [1:0] mem_dm; // lanes to keep
  logic [DQ_W-1:0] mem_wd; // write beat
  logic [3:0] lv; // filtered clock levels
  logic ck_edge;
  logic ck_rise;
  logic dk_edge;
  logic [19:0] a; // effective address
  logic [1:0] cmd;

  // =====================================
  // next state
  always_comb
  begin
    n = r;
    n.rf = 1'b0;
    n.ign = 1'b0;
    a = '0;
    cmd = '0;
    // every pin enters through three flops
    n.s1 = {link.dq, link.write_byte_mask, link.mirror_select, link.spare_chip_select,
            link.bank, link.addr, link.ref_n, link.we_n, link.cs_n,
            link.write_data_clock, link.command_clock};
    n.s2 = r.s1;
    n.s3 = r.s2;
    // the clocks change level only when stages two and three agree
    lv = ddrbm_pkg::ddrbm_lvl_filt({2'b00, r.s2[P_DK], r.s2[P_CK]},
                                   {2'b00, r.s3[P_DK], r.s3[P_CK]},
                                   {2'b00, r.dk_lvl, r.ck_lvl});
    n.ck_lvl = lv[0];
    n.dk_lvl = lv[1];
    ck_edge = lv[0] ^ r.ck_lvl;
    ck_rise = ck_edge & lv[0];
    dk_edge = lv[1] ^ r.dk_lvl;
    // read clocks follow the command clock, edge aligned with the beats
    n.qk = '0;
    n.qk[NQK-1:0] = {NQK{lv[0]}};
    mem_idx = {r.bank, r.col + COL_W'(r.beat)};
    mem_we = 1'b0;
    mem_dm = r.s3[P_DM +: 2];
    mem_wd = r.s3[P_DQ +: DQ_W];

    // read burst: one beat on every command clock edge
    if (r.st == ddrbm_pkg::D_RD && ck_edge)
    begin
      if (r.skip != 3'h0)
      begin
        n.skip = r.skip - 3'h1;
      end
      else if (r.beat == ddrbm_pkg::ddrbm_bl_words(r.bl))
      begin
        // bus released one half period after the last beat
        n.oe = 1'b0;
        n.vld = 1'b0;
        n.st = ddrbm_pkg::D_IDLE;
      end
      else
      begin
        n.dq = mem[mem_idx];
        n.oe = 1'b1;
        n.vld = 1'b1;
        n.beat = r.beat + 4'h1;
      end
    end

    // write burst: one beat on each edge of the write data clock
    if (r.st == ddrbm_pkg::D_WR && dk_edge)
    begin
      if (r.skip != 3'h0)
      begin
        n.skip = r.skip - 3'h1;
      end
      else
      begin
        mem_we = 1'b1;
        n.beat = r.beat + 4'h1;
        if (n.beat == ddrbm_pkg::ddrbm_bl_words(r.bl))
        begin
          n.st = ddrbm_pkg::D_IDLE;
        end
      end
    end

    // commands: only on a rise, only with chip select low
    if (ck_rise && !r.s3[P_CS])
    begin
      a = r.s3[P_A +: 20];
      // mirrored part: the spare select ball carries address bit five
      if (r.s3[P_MIR])
      begin
        a[5] = r.s3[P_SPARE];
      end
      cmd = {r.s3[P_WE], r.s3[P_REF]};
      case (cmd)
        `DDRBM_CMD_MRS:
        begin
          // a reserved length or a busy sequencer leaves the setting unchanged and flags the command ignored
          if (n.st == ddrbm_pkg::D_IDLE && a[`DDRBM_MR_BL_LSB +: 2] != `DDRBM_BL_BAD)
          begin
            n.bl = a[`DDRBM_MR_BL_LSB +: 2];
            n.dll = a[`DDRBM_MR_DLL_BIT];
          end
          else
          begin
            n.ign = 1'b1;
          end
        end
        `DDRBM_CMD_REF:
        begin
          // row comes from the bank's own counter, never from the address
          n.rf = 1'b1;
          n.rf_bank = r.s3[P_BA +: 4];
          n.rf_row = r.rows[r.s3[P_BA +: 4] * ROW_W +: ROW_W];
          n.rows[r.s3[P_BA +: 4] * ROW_W +: ROW_W] = n.rf_row + ROW_W'(1);
        end
        default:
        begin
          // reads and writes need the delay loop and an idle sequencer
          if (n.st != ddrbm_pkg::D_IDLE || !r.dll)
          begin
            n.ign = 1'b1;
          end
          else
          begin
            n.bank = r.s3[P_BA +: 4];
            n.col = a[COL_W-1:0];
            n.beat = 4'h0;
            if (cmd == `DDRBM_CMD_WRITE)
            begin
              n.st = ddrbm_pkg::D_WR;
              n.skip = 3'(2 * `DDRBM_WL);
            end
            else
            begin
              n.st = ddrbm_pkg::D_RD;
              n.skip = 3'(2 * `DDRBM_RL - 1);
            end
          end
        end
      endcase
    end
  end

  // =====================================
  // state register; reset drives the bus off and disables the loop
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  // =====================================
  // array write; a set mask bit keeps its lane
  always_ff @(posedge core_clk)
  begin
    if (mem_we)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!mem_dm[i])
        begin
          mem[mem_idx][i*LANE +: LANE] <= mem_wd[i*LANE +: LANE];
        end
      end
    end
  end

  // =====================================
  // outputs straight from the state register, except burst_words, which is decoded from the length code
  assign link.dev_dq = r.dq;
  assign link.dev_dq_oe = r.oe;
  assign link.read_data_clock = r.qk;
  assign link.read_valid_flag = r.vld;
  assign dll_on = r.dll;
  assign burst_words = ddrbm_pkg::ddrbm_bl_words(r.bl);
  assign refresh_pulse = r.rf;
  assign refresh_bank = r.rf_bank;
  assign refresh_row = r.rf_row;
  assign ignored_pulse = r.ign;
endmodule : ddrbm_device

// *** ddrbm_ctrl.sv ***
// controller end of the ddr burst link: clock divider, command and burst sequencer
`timescale 1ns/1ps
`include "ddrbm_params.svh"
module ddrbm_ctrl #(
  parameter int DQ_W = 36,
  parameter bit TWO_QK = 1'b0,
  parameter bit MIRROR = 1'b0,
  parameter logic [1:0] INIT_BL = `DDRBM_BL8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // link to the device
  ddrbm_if.ctl link,
  // request side
  input wire logic req_valid,
  input wire ddrbm_pkg::ddrbm_op_t req_op,
  input wire logic [3:0] req_bank,
  input wire logic [19:0] req_addr,
  input wire logic [8*DQ_W-1:0] req_wdata,
  input wire logic [15:0] req_mask,
  output logic req_ready,
  // answer side
  output logic rsp_valid,
  output logic [8*DQ_W-1:0] rsp_data,
  output logic init_done
);
  // =====================================
  // divider and vector sizes
  localparam int HALF = `DDRBM_LINK_HALF;
  localparam int PER = 2 * HALF;
  localparam int CW = $clog2(PER);
  localparam int NG = DQ_W / 9; // nine-line groups
  localparam int RW = 5 + DQ_W; // {dq, read clocks, valid}

  // whole control state of the controller
  typedef struct packed {
    logic [CW-1:0] cnt; // position in the link period
    logic ck;
    logic dk;
    logic cs_n;
    logic we_n;
    logic ref_n;
    logic [19:0] addr;
    logic [3:0] bank;
    ddrbm_pkg::ddrbm_hst_t st;
    ddrbm_pkg::ddrbm_op_t op;
    logic [8*DQ_W-1:0] wdata;
    logic [15:0] wmask;
    logic [1:0] bl; // length the device was set to
    logic [2:0] skip;
    logic [3:0] beat;
    logic [DQ_W-1:0] dq;
    logic oe;
    logic [1:0] dm;
    logic [RW-1:0] s1; // first sync stage, read only by s2
    logic [RW-1:0] s2;
    logic [RW-1:0] s3;
    logic [3:0] qk_lvl; // filtered read clocks
    logic [8*DQ_W-1:0] rdata;
    logic rsp;
    logic rdy;
    logic done;
  } ddrbm_ctl_st_t;

  ddrbm_ctl_st_t r; // registered state
  ddrbm_ctl_st_t n; // next state
  logic [CW-1:0] cnt_n;
  logic edge_ev; // any command clock edge this cycle
  logic fall_ev;
  logic [3:0] qk_new;
  logic [3:0] qe; // read clock edges seen
  logic fin; // current operation complete
  logic [1:0] qsel;

  // =====================================
  // next state
  always_comb
  begin
    n = r;
    n.rsp = 1'b0;
    fin = 1'b0;
    qsel = '0;
    // both link clocks come from one divider, the data clock a quarter late
    cnt_n = (r.cnt == CW'(PER - 1)) ? '0 : r.cnt + CW'(1);
    n.cnt = cnt_n;
    n.ck = (cnt_n < CW'(HALF));
    n.dk = (cnt_n >= CW'(`DDRBM_DK_OFS)) && (cnt_n < CW'(`DDRBM_DK_OFS + HALF));
    fall_ev = (cnt_n == CW'(HALF));
    edge_ev = fall_ev || (cnt_n == '0);
    // read side pins enter through three flops
    n.s1 = {link.dq, link.read_data_clock, link.read_valid_flag};
    n.s2 = r.s1;
    n.s3 = r.s2;
    qk_new = ddrbm_pkg::ddrbm_lvl_filt(r.s2[4:1], r.s3[4:1], r.qk_lvl);
    n.qk_lvl = qk_new;
    qe = qk_new ^ r.qk_lvl;

    // first operation after reset sets the length and enables the loop
    if (r.st == ddrbm_pkg::H_INIT)
    begin
      n.op = ddrbm_pkg::DDRBM_OP_MODE;
      n.addr = '0;
      n.addr[`DDRBM_MR_BL_LSB +: 2] = INIT_BL;
      n.addr[`DDRBM_MR_DLL_BIT] = 1'b1;
      n.st = ddrbm_pkg::H_CMD;
    end
    else if (r.st == ddrbm_pkg::H_IDLE && req_valid && r.rdy)
    begin
      n.op = req_op;
      n.addr = req_addr;
      n.bank = req_bank;
      n.wdata = req_wdata;
      n.wmask = req_mask;
      n.rdy = 1'b0;
      n.st = ddrbm_pkg::H_CMD;
    end

    // commands change on a fall so they are steady at the device's rise
    if (fall_ev)
    begin
      n.cs_n = 1'b1; // a command lasts one period
      if (r.st == ddrbm_pkg::H_CMD)
      begin
        n.cs_n = 1'b0;
        case (r.op)
          ddrbm_pkg::DDRBM_OP_READ: {n.we_n, n.ref_n} = `DDRBM_CMD_READ;
          ddrbm_pkg::DDRBM_OP_WRITE: {n.we_n, n.ref_n} = `DDRBM_CMD_WRITE;
          ddrbm_pkg::DDRBM_OP_REF: {n.we_n, n.ref_n} = `DDRBM_CMD_REF;
          default: {n.we_n, n.ref_n} = `DDRBM_CMD_MRS;
        endcase
        // a reserved length is dropped by the device, so keep ours as it was
        if (r.op == ddrbm_pkg::DDRBM_OP_MODE && r.addr[`DDRBM_MR_BL_LSB +: 2] != `DDRBM_BL_BAD)
        begin
          n.bl = r.addr[`DDRBM_MR_BL_LSB +: 2];
        end
        n.skip = 3'(2 * `DDRBM_WL);
        n.beat = 4'h0;
        n.rdata = '0;
        n.st = ddrbm_pkg::H_BUSY;
      end
    end

    if (r.st == ddrbm_pkg::H_BUSY)
    begin
      if (r.op == ddrbm_pkg::DDRBM_OP_READ)
      begin
        // each group is taken on the edge of the read clock that times it
        for (int g = 0; g < NG; g++)
        begin
          qsel = TWO_QK ? 2'(g % 2) : 2'(g);
          if (qe[qsel] && r.s3[0])
          begin
            n.rdata[r.beat*DQ_W + g*9 +: 9] = r.s3[5 + g*9 +: 9];
          end
        end
        if (qe[0] && r.s3[0])
        begin
          n.beat = r.beat + 4'h1;
        end
        fin = (n.beat == ddrbm_pkg::ddrbm_bl_words(r.bl));
        n.rsp = fin;
      end
      else if (edge_ev)
      begin
        if (r.skip != 3'h0)
        begin
          n.skip = r.skip - 3'h1;
        end
        else if (r.op != ddrbm_pkg::DDRBM_OP_WRITE)
        begin
          fin = 1'b1;
        end
        else if (r.beat == ddrbm_pkg::ddrbm_bl_words(r.bl))
        begin
          n.oe = 1'b0;
          fin = 1'b1;
        end
        else
        begin
          // beats change on both command clock edges
          n.dq = r.wdata[r.beat*DQ_W +: DQ_W];
          n.dm = r.wmask[r.beat*2 +: 2];
          n.oe = 1'b1;
          n.beat = r.beat + 4'h1;
        end
      end
    end

    // nothing new goes out before the current operation is over
    if (fin)
    begin
      n.st = ddrbm_pkg::H_IDLE;
      n.rdy = 1'b1;
      n.done = 1'b1;
    end
  end

  // =====================================
  // state register; reset parks chip select high
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.cs_n <= 1'b1;
      r.we_n <= 1'b1;
      r.ref_n <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // =====================================
  // outputs straight from the state register, except mirror select and the spare select gate, which come from MIRROR
  assign link.command_clock = r.ck;
  assign link.write_data_clock = r.dk;
  assign link.cs_n = r.cs_n;
  assign link.we_n = r.we_n;
  assign link.ref_n = r.ref_n;
  assign link.addr = r.addr;
  assign link.bank = r.bank;
  assign link.spare_chip_select = MIRROR ? r.addr[5] : 1'b0;
  assign link.mirror_select = MIRROR;
  assign link.ctl_dq = r.dq;
  assign link.ctl_dq_oe = r.oe;
  assign link.write_byte_mask = r.dm;
  assign req_ready = r.rdy;
  assign rsp_valid = r.rsp;
  assign rsp_data = r.rdata;
  assign init_done = r.done;
endmodule : ddrbm_ctrl

// *** ddrbm_link_monitor.sv ***
// concurrent checks on the link wires between controller and device
`timescale 1ns/1ps
module ddrbm_link_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // command side
  input wire logic command_clock,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic ref_n,
  input wire logic [19:0] addr,
  input wire logic [3:0] bank,
  input wire logic spare_chip_select,
  input wire logic mirror_select,
  // data side
  input wire logic write_data_clock,
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe,
  input wire logic [3:0] read_data_clock,
  input wire logic read_valid_flag
);
  // =====
  // one domain: core clock, reset held low disables all
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // command launched on a low clock, so the rise samples it mid-window
  property p_cmd_launch;
    $fell(cs_n) |-> !command_clock ##4 command_clock;
  endproperty
  a_cmd_launch: assert property (p_cmd_launch) else $error("command not centred on rise");
  // code, address and bank hold while select is low
  property p_cmd_hold;
    !cs_n && !$past(cs_n) |-> $stable({we_n, ref_n, addr, bank});
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command moved while selected");
  // write data clock trails the command clock by two core cycles
  // divider restarts mid-phase after reset, so the history must postdate it
  property p_dk_lag;
    $past(nrst, 3) |-> write_data_clock == $past(command_clock, 2);
  endproperty
  a_dk_lag: assert property (p_dk_lag) else $error("write clock phase wrong");
  // every nine-line group has its own copy of the read clock
  property p_qk_groups;
    read_data_clock == {4{read_data_clock[0]}};
  endproperty
  a_qk_groups: assert property (p_qk_groups) else $error("read clocks differ");
  // device drives the lines exactly while it flags valid beats
  property p_oe_valid;
    dev_dq_oe == read_valid_flag;
  endproperty
  a_oe_valid: assert property (p_oe_valid) else $error("drive and valid differ");
  // the two ends never drive the shared lines together
  property p_no_fight;
    !(dev_dq_oe && ctl_dq_oe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive");
  // shortest burst is two beats of a half period each
  property p_beat_min;
    $rose(read_valid_flag) |-> read_valid_flag [*8];
  endproperty
  a_beat_min: assert property (p_beat_min) else $error("read burst too short");
  // first beat leaves together with a read clock rise
  property p_beat_clk;
    $rose(read_valid_flag) |-> $rose(read_data_clock[0]);
  endproperty
  a_beat_clk: assert property (p_beat_clk) else $error("beat not on read clock");
  // spare select copies address bit five when mirroring
  property p_mirror;
    !cs_n && mirror_select |-> spare_chip_select == addr[5];
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror bit wrong");
  // a read returns its first beat one link period after the command
  property p_rd_lat;
    $fell(cs_n) && we_n && ref_n |-> ##[8:30] $rose(read_valid_flag);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  // write data follows its command one link period later
  property p_wr_lat;
    $fell(cs_n) && !we_n && ref_n |-> ##[10:14] $rose(ctl_dq_oe);
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write data late");
endmodule : ddrbm_link_monitor

// *** tb_top.sv ***
// self-checking bench: controller and device joined on one link
`timescale 1ns/1ps
`include "ddrbm_params.svh"
module tb_top;
  localparam int W = 36;
  // =====
  // request side, driven at rising edges
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  ddrbm_pkg::ddrbm_op_t req_op = ddrbm_pkg::DDRBM_OP_READ;
  logic [3:0] req_bank = 4'h0;
  logic [19:0] req_addr = 20'h00000;
  logic [8*W-1:0] req_wdata = '0;
  logic [15:0] req_mask = 16'h0000;
  logic req_ready, rsp_valid, init_done, dll_on, refresh_pulse, ignored_pulse;
  logic [8*W-1:0] rsp_data;
  logic [3:0] burst_words, refresh_bank;
  logic [7:0] refresh_row;
  // =====
  // scoreboard state
  int n_mismatch = 0;
  int num_checks = 0;
  int n_ign = 0; // dropped commands seen
  int n_ref = 0; // refreshes seen
  logic [8*W-1:0] exp_q[$];
  int nw_q[$];
  logic [3:0] bank_q[$];
  logic [15:0] lfsr = 16'h003F; // fixed seed
  logic [8*W-1:0] img, wd; // expected array contents, write data
  logic [15:0] mk;
  logic [3:0] b;
  logic [19:0] a;
  logic [1:0] codes [3] = '{`DDRBM_BL2, `DDRBM_BL4, `DDRBM_BL8};
  int nws [3] = '{2, 4, 8};

  always #4 core_clk = ~core_clk;

  ddrbm_if #(.DQ_W(W)) link ();
  // mirroring on and two read clocks only, so both paths are live
  ddrbm_ctrl #(.DQ_W(W), .TWO_QK(1'b1), .MIRROR(1'b1)) i_ddrbm_ctrl (
    .core_clk(core_clk), .nrst(nrst),
    .link(link), .req_valid(req_valid), .req_op(req_op), .req_bank(req_bank),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_mask(req_mask), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done(init_done));
  ddrbm_device #(.DQ_W(W)) i_ddrbm_device (.core_clk(core_clk), .nrst(nrst), .link(link),
    .dll_on(dll_on), .burst_words(burst_words), .refresh_pulse(refresh_pulse),
    .refresh_bank(refresh_bank), .refresh_row(refresh_row), .ignored_pulse(ignored_pulse));
  ddrbm_link_monitor i_ddrbm_link_monitor (.core_clk(core_clk), .nrst(nrst),
    .command_clock(link.command_clock), .cs_n(link.cs_n), .we_n(link.we_n),
    .ref_n(link.ref_n), .addr(link.addr), .bank(link.bank),
    .spare_chip_select(link.spare_chip_select), .mirror_select(link.mirror_select),
    .write_data_clock(link.write_data_clock), .ctl_dq_oe(link.ctl_dq_oe),
    .dev_dq_oe(link.dev_dq_oe), .read_data_clock(link.read_data_clock),
    .read_valid_flag(link.read_valid_flag));

  // =====
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // fills a whole burst with random words
  task automatic rnd(output logic [8*W-1:0] v);
    for (int i = 0; i < 18; i++)
    begin
      lfsr = lfsr_next(lfsr);
      v[i*16 +: 16] = lfsr;
    end
  endtask : rnd

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task automatic check_val(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t exp=%0h got=%0h", $time, exp, got);
    end
  endtask : check_val

  // only the words of the burst length are meaningful
  task automatic check_burst(input logic [8*W-1:0] exp, input logic [8*W-1:0] got, input int nw);
    logic [8*W-1:0] keep;
    keep = '0;
    for (int k = 0; k < nw; k++)
      keep[k*W +: W] = '1;
    num_checks++;
    if ((got & keep) !== (exp & keep))
    begin
      n_mismatch++;
      $display("BAD t=%0t exp=%0h got=%0h", $time, exp & keep, got & keep);
    end
  endtask : check_burst

  // starts one edge on, so a take just made is not seen as ready again
  task automatic wait_ready();
    int i;
    i = 0;
    do
    begin
      @(posedge core_clk);
      i++;
    end
    while (req_ready !== 1'b1 && i < 600);
    if (req_ready !== 1'b1)
    begin
      n_mismatch++;
      conclude();
    end
  endtask : wait_ready

  task automatic issue(input ddrbm_pkg::ddrbm_op_t op, input logic [3:0] bk, input logic [19:0] ad,
                       input logic [8*W-1:0] d, input logic [15:0] m);
    wait_ready();
    req_valid <= 1'b1;
    req_op <= op;
    req_bank <= bk;
    req_addr <= ad;
    req_wdata <= d;
    req_mask <= m;
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask : issue

  // =====
  // result watcher: oldest note against each answer
  always @(posedge core_clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check_val(32'h1, 32'h0);
      else
        check_burst(exp_q.pop_front(), rsp_data, nw_q.pop_front());
    end
    if (refresh_pulse === 1'b1)
    begin
      check_val(32'(bank_q.pop_front()), 32'(refresh_bank));
      check_val(n_ref, 32'(refresh_row));
      n_ref++;
    end
    if (ignored_pulse === 1'b1)
      n_ign++;
  end

  // =====
  // main sequence
  initial
  begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    wait_ready();
    check_val(32'(init_done), 32'h1);
    check_val(32'(dll_on), 32'h1);
    check_val(32'(burst_words), 32'h8);
    // same bank twice: rows come from the inside counter
    lfsr = lfsr_next(lfsr);
    b = lfsr[3:0];
    repeat (2)
    begin
      bank_q.push_back(b);
      issue(ddrbm_pkg::DDRBM_OP_REF, b, 20'hFFFFF, '0, 16'h0000);
    end
    // every burst length: full write, masked overwrite, read back
    for (int j = 0; j < 3; j++)
    begin
      issue(ddrbm_pkg::DDRBM_OP_MODE, 4'h0, {17'h0, 1'b1, codes[j]}, '0, 16'h0000);
      wait_ready();
      check_val(32'(burst_words), nws[j]);
      lfsr = lfsr_next(lfsr);
      b = lfsr[3:0];
      a = {14'h0, lfsr[9:4]};
      rnd(img);
      issue(ddrbm_pkg::DDRBM_OP_WRITE, b, a, img, 16'h0000);
      rnd(wd);
      lfsr = lfsr_next(lfsr);
      mk = lfsr;
      issue(ddrbm_pkg::DDRBM_OP_WRITE, b, a, wd, mk);
      for (int k = 0; k < 16; k++)
        if (!mk[k])
          img[k*18 +: 18] = wd[k*18 +: 18];
      exp_q.push_back(img);
      nw_q.push_back(nws[j]);
      issue(ddrbm_pkg::DDRBM_OP_READ, b, a, '0, 16'h0000);
    end
    // reserved length code is dropped
    issue(ddrbm_pkg::DDRBM_OP_MODE, 4'h0, 20'h00007, '0, 16'h0000);
    wait_ready();
    check_val(32'(burst_words), 32'h8);
    // loop off: a write must not reach the array
    issue(ddrbm_pkg::DDRBM_OP_MODE, 4'h0, 20'h00002, '0, 16'h0000);
    wait_ready();
    check_val(32'(dll_on), 32'h0);
    rnd(wd);
    issue(ddrbm_pkg::DDRBM_OP_WRITE, b, a, wd, 16'h0000);
    issue(ddrbm_pkg::DDRBM_OP_MODE, 4'h0, 20'h00006, '0, 16'h0000);
    exp_q.push_back(img);
    nw_q.push_back(8);
    issue(ddrbm_pkg::DDRBM_OP_READ, b, a, '0, 16'h0000);
    for (int i = 0; i < 600 && exp_q.size() > 0; i++)
      @(posedge core_clk);
    check_val(32'(exp_q.size()), 32'h0);
    check_val(n_ign, 32'h2);
    check_val(n_ref, 32'h2);
    conclude();
  end
endmodule : tb_top
